// ==== core_pkg.sv ====
// Purpose: Constants and types for the 14-bit-word core execute block
// Assumes: One pclk, one instruction cycle is four phase enables
// Notes:   Register map reached over APB, one aligned word per register
package core_pkg;
   localparam int          INSTR_W       = 14;
   localparam int          PC_W          = 13;
   localparam int          STACK_DEPTH   = 8;
   localparam int          FILE_ADDR_W   = 7;
   localparam int          BANK_BYTES    = 128;
   localparam int          PAGE_W        = 11;
   localparam int          PHASES        = 4;
   localparam logic [12:0] RESET_VECTOR  = 13'h0000;
   localparam logic [12:0] IRQ_VECTOR    = 13'h0004;
   localparam int          GIE_BIT       = 7;
   localparam logic [7:0]  OPTION_RESET  = 8'hff;
   // APB register offsets
   localparam logic [7:0]  ADDR_CTRL     = 8'h00;
   localparam logic [7:0]  ADDR_INSTR    = 8'h04;
   localparam logic [7:0]  ADDR_ACC      = 8'h08;
   localparam logic [7:0]  ADDR_STATUS   = 8'h0c;
   localparam logic [7:0]  ADDR_OPTION   = 8'h10;
   localparam logic [7:0]  ADDR_IRQCTL   = 8'h14;
   localparam logic [7:0]  ADDR_PC       = 8'h18;
   localparam logic [7:0]  ADDR_LATCH    = 8'h1c;
   localparam logic [7:0]  ADDR_POINTER  = 8'h20;
   localparam logic [7:0]  ADDR_FDATA    = 8'h24;
   localparam logic [7:0]  ADDR_PRESC    = 8'h28;
   // Status bit positions
   localparam int          ZERO_BIT      = 2;
   localparam int          BUSY_BIT      = 8;
   // Opcodes
   localparam logic [13:0] OP_IRET       = 14'h0009;
   localparam logic [13:0] OP_OPTION     = 14'h0062;
   localparam logic [13:0] NOP_MASK      = 14'h3f9f;
   localparam logic [13:0] NOP_CODE      = 14'h0000;
   localparam logic [3:0]  PFX_BSET      = 4'h5;
   localparam logic [3:0]  PFX_BTSC      = 4'h6;
   localparam logic [5:0]  PFX_XORL      = 6'h3a;
   localparam logic [5:0]  PFX_XORF      = 6'h06;

   typedef enum logic [3:0] {
      OPK_NOP, OPK_BSET, OPK_BTSC, OPK_IRET, OPK_OPTION, OPK_XORL, OPK_XORF, OPK_ILLEGAL
   } opkind_t;

   typedef struct packed {
      opkind_t                kind;
      logic [2:0]             bit_idx;
      logic [FILE_ADDR_W-1:0] faddr;
      logic [7:0]             literal;
      logic                   dest_file;
   } decoded_t;
endpackage

// ==== instr_decoder.sv ====
// Purpose: Combinational decode of a 14-bit instruction word
// Assumes: Word valid for the whole instruction cycle
// Notes:   Unknown opcodes execute as idle cycles
module instr_decoder
   import core_pkg::*;
(
   input  wire logic [INSTR_W-1:0] instr,
   output decoded_t                dec
);
   always_comb begin
      dec           = '0;
      dec.bit_idx   = instr[9:7];
      dec.faddr     = instr[6:0];
      dec.literal   = instr[7:0];
      dec.dest_file = instr[7];
      if ((instr & NOP_MASK) == NOP_CODE) begin
         dec.kind = OPK_NOP;
      end else if (instr == OP_IRET) begin
         dec.kind = OPK_IRET;
      end else if (instr == OP_OPTION) begin
         dec.kind = OPK_OPTION;
      end else if (instr[13:10] == PFX_BSET) begin
         dec.kind = OPK_BSET;
      end else if (instr[13:10] == PFX_BTSC) begin
         dec.kind = OPK_BTSC;
      end else if (instr[13:8] == PFX_XORL) begin
         dec.kind = OPK_XORL;
      end else if (instr[13:8] == PFX_XORF) begin
         dec.kind = OPK_XORF;
      end else begin
         dec.kind = OPK_ILLEGAL;
      end
   end
endmodule

// ==== ret_stack.sv ====
// Purpose: Hardware return-address stack, circular
// Assumes: Push and pop never in the same cycle
// Notes:   Overflow wraps and overwrites the oldest entry
module ret_stack
   import core_pkg::*;
#(
   parameter int DEPTH = STACK_DEPTH
)
(
   input  wire logic            pclk,
   input  wire logic            presetn,
   input  wire logic            push,
   input  wire logic            pop,
   input  wire logic [PC_W-1:0] push_data,
   output logic      [PC_W-1:0] top_entry
);
   localparam int PTR_W = $clog2(DEPTH);
   logic [PC_W-1:0]  mem_ff [DEPTH];
   logic [PTR_W-1:0] sp_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_ff <= '0;
      end else if (push) begin
         sp_ff <= sp_ff + 1'b1;
      end else if (pop) begin
         sp_ff <= sp_ff - 1'b1;
      end
   end

   always_ff @(posedge pclk) begin
      if (push) begin
         mem_ff[sp_ff] <= push_data;
      end
   end

   assign top_entry = mem_ff[sp_ff - 1'b1];
endmodule

// ==== core_exec.sv ====
// Purpose: Execute unit of the 14-bit-word core with APB register access
// Assumes: Software loads a word into the instruction register to issue it
// Notes:   One file byte stands in for the addressed register
module core_exec
   import core_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        irq_request,
   output logic             cycle_done
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef enum logic [1:0] {S_IDLE, S_RUN, S_IDLE2} exec_state_t;

   exec_state_t      state_ff;
   logic [1:0]       phase_ff;
   logic [INSTR_W-1:0] instr_ff;
   logic [7:0]       acc_ff;
   logic             zero_ff;
   logic [7:0]       option_ff;
   logic [7:0]       irqctl_ff;
   logic [PC_W-1:0]  pc_ff;
   logic [4:0]       latch_ff;
   logic [7:0]       pointer_ff;
   logic [7:0]       fdata_ff;
   logic [7:0]       operand_ff;
   logic [7:0]       result_ff;
   logic             skip_ff;
   logic [8:0]       presc_ff;
   logic             start;
   logic             wr_en;
   logic             phase_last;
   logic             push;
   logic             pop;
   logic [PC_W-1:0]  top_entry;
   decoded_t         dec;

   instr_decoder u_dec (
      .instr (instr_ff),
      .dec   (dec)
   );

   ret_stack #(.DEPTH(STACK_DEPTH)) u_stack (
      .pclk      (pclk),
      .presetn   (presetn),
      .push      (push),
      .pop       (pop),
      .push_data (pc_ff),
      .top_entry (top_entry)
   );

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   assign pready  = 1'b1;
   assign wr_en   = psel && penable && pwrite;
   assign start   = wr_en && (paddr == ADDR_INSTR) && (state_ff == S_IDLE);
   assign pslverr = psel && penable && (paddr > ADDR_PRESC);

   always_comb begin
      prdata = '0;
      unique case (paddr)
         ADDR_CTRL:    prdata = {31'h0, state_ff != S_IDLE};
         ADDR_INSTR:   prdata = {18'h0, instr_ff};
         ADDR_ACC:     prdata = {24'h0, acc_ff};
         ADDR_STATUS:  prdata = {23'h0, state_ff != S_IDLE, 5'h0, zero_ff, 2'h0};
         ADDR_OPTION:  prdata = {24'h0, option_ff};
         ADDR_IRQCTL:  prdata = {24'h0, irqctl_ff};
         ADDR_PC:      prdata = {19'h0, pc_ff};
         ADDR_LATCH:   prdata = {27'h0, latch_ff};
         ADDR_POINTER: prdata = {24'h0, pointer_ff};
         ADDR_FDATA:   prdata = {24'h0, fdata_ff};
         ADDR_PRESC:   prdata = {23'h0, presc_ff};
         default:      prdata = '0;
      endcase
   end

   // ----------------------------------------
   // Phase sequencer
   // ----------------------------------------
   assign phase_last = (phase_ff == 2'd3);
   assign cycle_done = (state_ff != S_IDLE) && phase_last;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= S_IDLE;
         phase_ff <= 2'd0;
      end else begin
         unique case (state_ff)
            S_IDLE: begin
               phase_ff <= 2'd0;
               if (start) begin
                  state_ff <= S_RUN;
               end
            end
            S_RUN: begin
               phase_ff <= phase_ff + 2'd1;
               if (phase_last) begin
                  state_ff <= ((dec.kind == OPK_IRET) || skip_ff) ? S_IDLE2 : S_IDLE;
               end
            end
            S_IDLE2: begin
               phase_ff <= phase_ff + 2'd1;
               if (phase_last) begin
                  state_ff <= S_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr_ff <= '0;
      end else if (start) begin
         instr_ff <= pwdata[INSTR_W-1:0];
      end
   end

   // ----------------------------------------
   // Datapath: read Q2, compute Q3, write Q4
   // ----------------------------------------
   logic run;
   assign run = (state_ff == S_RUN);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         operand_ff <= '0;
         result_ff  <= '0;
         skip_ff    <= 1'b0;
      end else if (run && phase_ff == 2'd1) begin
         operand_ff <= (dec.kind == OPK_XORL) ? dec.literal : fdata_ff;
         skip_ff    <= 1'b0;
      end else if (run && phase_ff == 2'd2) begin
         unique case (dec.kind)
            OPK_BSET: result_ff <= operand_ff | (8'h01 << dec.bit_idx);
            OPK_BTSC: skip_ff   <= ~operand_ff[dec.bit_idx];
            OPK_XORL,
            OPK_XORF: result_ff <= acc_ff ^ operand_ff;
            default:  result_ff <= result_ff;
         endcase
      end
   end

   logic write_ph;
   assign write_ph = run && phase_last;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_ff  <= '0;
         zero_ff <= 1'b0;
      end else if (wr_en && paddr == ADDR_ACC) begin
         acc_ff <= pwdata[7:0];
      end else if (write_ph) begin
         if (dec.kind == OPK_XORL || (dec.kind == OPK_XORF && !dec.dest_file)) begin
            acc_ff <= result_ff;
         end
         if (dec.kind == OPK_XORL || dec.kind == OPK_XORF) begin
            zero_ff <= (result_ff == 8'h00);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fdata_ff <= '0;
      end else if (wr_en && paddr == ADDR_FDATA) begin
         fdata_ff <= pwdata[7:0];
      end else if (write_ph && (dec.kind == OPK_BSET ||
                                (dec.kind == OPK_XORF && dec.dest_file))) begin
         fdata_ff <= result_ff;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         option_ff <= OPTION_RESET;
      end else if (wr_en && paddr == ADDR_OPTION) begin
         option_ff <= pwdata[7:0];
      end else if (write_ph && dec.kind == OPK_OPTION) begin
         option_ff <= acc_ff;
      end
   end

   // ----------------------------------------
   // Interrupt enable, program counter, stack
   // ----------------------------------------
   logic take_irq;
   assign take_irq = (state_ff == S_IDLE) && !start && irq_request && irqctl_ff[GIE_BIT];
   assign pop  = write_ph && dec.kind == OPK_IRET;
   assign push = take_irq;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irqctl_ff <= '0;
      end else if (run && phase_ff == 2'd2 && dec.kind == OPK_IRET) begin
         irqctl_ff[GIE_BIT] <= 1'b1;
      end else if (take_irq) begin
         irqctl_ff[GIE_BIT] <= 1'b0;
      end else if (wr_en && paddr == ADDR_IRQCTL) begin
         irqctl_ff <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_ff <= RESET_VECTOR;
      end else if (take_irq) begin
         pc_ff <= IRQ_VECTOR;
      end else if (pop) begin
         pc_ff <= top_entry;
      end else if (wr_en && paddr == ADDR_PC) begin
         pc_ff <= {latch_ff[4 -: PC_W-PAGE_W], pwdata[PAGE_W-1:0]};
      end else if (cycle_done && dec.kind != OPK_IRET) begin
         pc_ff <= pc_ff + 13'd1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_ff   <= '0;
         pointer_ff <= '0;
      end else if (wr_en && paddr == ADDR_LATCH) begin
         latch_ff <= pwdata[4:0];
      end else if (wr_en && paddr == ADDR_POINTER) begin
         pointer_ff <= pwdata[7:0];
      end
   end

   // Prescaler: ratio 2^(option[2:0]+1), from 2 to 256
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_ff <= '0;
      end else if (cycle_done) begin
         if (presc_ff >= ((9'd2 << option_ff[2:0]) - 9'd1)) begin
            presc_ff <= '0;
         end else begin
            presc_ff <= presc_ff + 9'd1;
         end
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence iret_first;
      run && dec.kind == OPK_IRET && phase_ff == 2'd0;
   endsequence

   sequence btsc_last;
      write_ph && dec.kind == OPK_BTSC;
   endsequence

   gie_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      iret_first |-> ##3 irqctl_ff[GIE_BIT])
      else $error("enable not set by interrupt return");
   iret_two_a: assert property (@(posedge pclk) disable iff (!presetn)
      iret_first |-> ##4 (state_ff == S_IDLE2) ##4 (state_ff == S_IDLE))
      else $error("interrupt return not two cycles");
   iret_pc_a: assert property (@(posedge pclk) disable iff (!presetn)
      iret_first |-> ##3 pop ##1 (pc_ff == $past(top_entry)) ##4 $stable(pc_ff))
      else $error("return address not kept");
   cycle_len_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state_ff == S_IDLE) ##1 run |-> ##3 cycle_done)
      else $error("cycle not four phases");
   irq_vec_a: assert property (@(posedge pclk) disable iff (!presetn)
      take_irq |=> pc_ff == IRQ_VECTOR)
      else $error("interrupt vector wrong");
   xor_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      write_ph && dec.kind == OPK_XORL |=> zero_ff == (acc_ff == 8'h00))
      else $error("zero flag wrong");
   xor_file_a: assert property (@(posedge pclk) disable iff (!presetn)
      write_ph && dec.kind == OPK_XORF && dec.dest_file |=>
         $stable(acc_ff) && zero_ff == (fdata_ff == 8'h00))
      else $error("xor to file wrong");
   bset_a: assert property (@(posedge pclk) disable iff (!presetn)
      write_ph && dec.kind == OPK_BSET |=> fdata_ff[$past(dec.bit_idx)] && $stable(zero_ff))
      else $error("bit set failed");
   skip_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
      btsc_last |=> (state_ff == S_IDLE2) == !$past(operand_ff[dec.bit_idx]))
      else $error("skip decision wrong");
   btsc_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
      btsc_last |=> $stable(fdata_ff) && $stable(acc_ff) && $stable(zero_ff))
      else $error("bit test changed state");
   option_a: assert property (@(posedge pclk) disable iff (!presetn)
      write_ph && dec.kind == OPK_OPTION |=> option_ff == $past(acc_ff))
      else $error("option load failed");
   nop_a: assert property (@(posedge pclk) disable iff (!presetn)
      write_ph && dec.kind == OPK_NOP |=> $stable(acc_ff) && $stable(fdata_ff))
      else $error("no-operation changed state");
endmodule

// ==== bit_logic_return_instr_exec_tb.sv ====
// Purpose: Self-checking bench for the core execute block over APB
// Assumes: Zero-wait APB slave, busy in STATUS bit 8, one file byte at FDATA
// Notes:   Instructions issued by writing INSTR, completion polled on busy
module bit_logic_return_instr_exec_tb
   import core_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        pclk        = 1'b0;
   logic        presetn     = 1'b0;
   logic        psel        = 1'b0;
   logic        penable     = 1'b0;
   logic        pwrite      = 1'b0;
   logic [7:0]  paddr       = 8'h00;
   logic [31:0] pwdata      = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq_request = 1'b0;
   logic        cycle_done;
   int          n_errors    = 0;
   int          cmp_count   = 0;
   int          n_done      = 0;
   int          cyc         = 0;
   logic [31:0] v;
   logic [31:0] p;
   logic        e;

   core_exec u_core_exec (
      .pclk        (pclk),
      .presetn     (presetn),
      .psel        (psel),
      .penable     (penable),
      .pwrite      (pwrite),
      .paddr       (paddr),
      .pwdata      (pwdata),
      .prdata      (prdata),
      .pready      (pready),
      .pslverr     (pslverr),
      .irq_request (irq_request),
      .cycle_done  (cycle_done)
   );

   always #2 pclk = ~pclk;

   // ----------------------------------------
   // Monitors and timeout
   // ----------------------------------------
   always @(posedge pclk) begin
      if (presetn === 1'b1 && cycle_done === 1'b1) begin
         n_done++;
      end
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         final_report();
      end
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   // Setup phase, then access phase held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, a, d, rd, err);
   endtask

   task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp, input string msg);
      logic [31:0] rd;
      logic        err;
      apb(1'b0, a, 32'h0, rd, err);
      check(rd, exp, msg);
   endtask

   // Issue one word, wait for busy to drop, compare instruction cycles seen
   task automatic exec(input logic [13:0] w, input int ncyc);
      logic [31:0] s;
      logic        err;
      n_done = 0;
      wr_reg(ADDR_INSTR, {18'h0, w});
      s = 32'h100;
      while (s[BUSY_BIT] !== 1'b0) apb(1'b0, ADDR_STATUS, 32'h0, s, err);
      check(32'(n_done), 32'(ncyc), "cycle count");
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      chk_reg(ADDR_PC, 32'h0, "reset pc");
      chk_reg(ADDR_OPTION, 32'hff, "reset option");
      chk_reg(ADDR_ACC, 32'h0, "reset acc");
      apb(1'b0, 8'h2c, 32'h0, v, e);
      check({31'h0, e}, 32'h1, "unmapped error");
      wr_reg(ADDR_POINTER, 32'hff);
      chk_reg(ADDR_POINTER, 32'hff, "pointer width");
      // Xor literal and zero flag
      wr_reg(ADDR_ACC, 32'hb5);
      exec(14'h3aaf, 1);
      chk_reg(ADDR_ACC, 32'h1a, "xor literal");
      chk_reg(ADDR_STATUS, 32'h0, "zero clear");
      exec(14'h3a1a, 1);
      chk_reg(ADDR_ACC, 32'h0, "xor literal zero");
      chk_reg(ADDR_STATUS, 32'h4, "zero set");
      // Bit set at top file address, flags kept
      wr_reg(ADDR_FDATA, 32'h0a);
      exec(14'h1400 | (14'd7 << 7) | 14'h7f, 1);
      chk_reg(ADDR_FDATA, 32'h8a, "bit set");
      chk_reg(ADDR_STATUS, 32'h4, "bit set flags");
      // Option load from accumulator
      exec(OP_OPTION, 1);
      chk_reg(ADDR_OPTION, 32'h0, "option load");
      chk_reg(ADDR_STATUS, 32'h4, "option flags");
      // Xor with file, both destinations
      wr_reg(ADDR_ACC, 32'hb5);
      wr_reg(ADDR_FDATA, 32'haf);
      exec(14'h0600 | 14'h0080 | 14'h7f, 1);
      chk_reg(ADDR_FDATA, 32'h1a, "xor to file");
      chk_reg(ADDR_ACC, 32'hb5, "xor to file acc");
      chk_reg(ADDR_STATUS, 32'h0, "xor file zero");
      exec(14'h0600 | 14'h7f, 1);
      chk_reg(ADDR_ACC, 32'haf, "xor to acc");
      chk_reg(ADDR_FDATA, 32'h1a, "xor to acc file");
      // No-operation with every don't-care pattern
      for (int x = 0; x < 4; x++) begin
         apb(1'b0, ADDR_PC, 32'h0, p, e);
         apb(1'b0, ADDR_PRESC, 32'h0, v, e);
         exec(14'(x << 5), 1);
         chk_reg(ADDR_PC, p + 32'h1, "nop pc");
         chk_reg(ADDR_PRESC, v ^ 32'h1, "divide by two");
         chk_reg(ADDR_ACC, 32'haf, "nop acc");
         chk_reg(ADDR_FDATA, 32'h1a, "nop file");
      end
      // Bit test skip: bit 1 set runs on, bit 0 clear idles a second cycle
      exec(14'h1800 | (14'd1 << 7) | 14'h7f, 1);
      apb(1'b0, ADDR_PC, 32'h0, p, e);
      exec(14'h1800 | 14'h7f, 2);
      chk_reg(ADDR_PC, p + 32'h2, "skip pc");
      chk_reg(ADDR_FDATA, 32'h1a, "skip file");
      // Paging from the upper latch
      wr_reg(ADDR_LATCH, 32'h18);
      wr_reg(ADDR_PC, 32'h123);
      chk_reg(ADDR_PC, 32'h1923, "paged pc");
      wr_reg(ADDR_LATCH, 32'h0);
      wr_reg(ADDR_PC, 32'h123);
      // Interrupt masked, then taken, then returned
      wr_reg(ADDR_IRQCTL, 32'h0);
      irq_request <= 1'b1;
      repeat (10) @(posedge pclk);
      chk_reg(ADDR_PC, 32'h123, "masked irq");
      wr_reg(ADDR_IRQCTL, 32'h80);
      v = 32'h0;
      for (int k = 0; k < 20 && v !== 32'h4; k++) apb(1'b0, ADDR_PC, 32'h0, v, e);
      check(v, 32'h4, "irq vector");
      // Nest further interrupts until the stack is full
      for (int i = 1; i < STACK_DEPTH; i++) begin
         wr_reg(ADDR_PC, 32'h100 + 32'(i));
         wr_reg(ADDR_IRQCTL, 32'h80);
         chk_reg(ADDR_PC, 32'h4, "nested vector");
      end
      irq_request <= 1'b0;
      chk_reg(ADDR_IRQCTL, 32'h0, "irq enable cleared");
      for (int i = STACK_DEPTH - 1; i > 0; i--) begin
         exec(OP_IRET, 2);
         chk_reg(ADDR_PC, 32'h100 + 32'(i), "nested return");
      end
      exec(OP_IRET, 2);
      chk_reg(ADDR_PC, 32'h123, "return pc");
      chk_reg(ADDR_IRQCTL, 32'h80, "return enable");
      final_report();
   end
endmodule
